//--- svrpg_hold_filter.sv
`timescale 1ns/1ps
module svrpg_hold_filter #(
   parameter int unsigned FILT_CYC = svrpg_pkg::FILT_CYC
) (
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic manual_hold_n_in,
   output logic      hold_req
);

   localparam int unsigned CW = $clog2(FILT_CYC + 1);

   if (FILT_CYC < 1) begin : g_chk
      $error("filter length must be at least one cycle");
   end

   typedef struct packed {
      logic          meta;
      logic          sync;
      logic [CW-1:0] low_cnt;
      logic          req;
   } svrpg_filt_state_type;

   localparam svrpg_filt_state_type RESET_STATE = '{
      meta: 1'h1, sync: 1'h1, low_cnt: '0, req: 1'h0};

   svrpg_filt_state_type q;
   svrpg_filt_state_type d;

   ////////////////////////////////////////////////////////////////////////////
   // sync then low-run filter
   always_comb begin
      d = q;
      d.meta = manual_hold_n_in;
      d.sync = q.meta;
      if (q.sync) begin
         d.low_cnt = '0;
         d.req = 1'h0;
      end else if (q.low_cnt == CW'(FILT_CYC - 1)) begin
         d.req = 1'h1;
      end else begin
         d.low_cnt = q.low_cnt + CW'(1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign hold_req = q.req;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_low_run;
      !q.sync [*3];
   endsequence

   a_glitch_reject: assert property ($rose(q.req) |-> $past(!q.sync, 1) &&
         $past(!q.sync, 2) && $past(!q.sync, 3))
      else $error("hold request from a low run shorter than the filter");

   a_low_sets_req: assert property (s_low_run |=> q.req)
      else $error("steady low hold input did not raise the request");

   a_open_no_req: assert property (manual_hold_n_in [*3] |=> !q.req)
      else $error("open hold input still requests reset");

endmodule

//--- svrpg_mcu_model.sv
`timescale 1ns/1ps
module svrpg_mcu_model #(
   parameter svrpg_pkg::svrpg_out_mode_type OUT_MODE = svrpg_pkg::OUT_PUSH_LOW
) (
   input  wire logic pin_val,
   input  wire logic pin_en,
   output logic      line,
   output logic      in_reset
);
   ////////////////////////////////////////////////////////////////////////////
   // released pin floats up to the pull-up
   assign line = pin_en ? pin_val : 1'b1;
   // held-in-reset level per output build
   assign in_reset = (OUT_MODE == svrpg_pkg::OUT_PUSH_HIGH) ? line : !line;
endmodule

//--- svrpg_pkg.sv
package svrpg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam real CLK_PERIOD_NS = 40.0;
   localparam real REL_SHORT_MS  = 1.09;
   localparam real REL_MID_MS    = 17.5;
   localparam real REL_LONG_MS   = 140.0;
   localparam real FILT_MIN_NS   = 100.0;
   localparam real ASSERT_MAX_US = 50.0;
   localparam real NS_PER_MS     = 1.0e6;
   localparam real NS_PER_US     = 1.0e3;
   localparam real ROUND_SLACK   = 1.0e-6;

   // least time, rounded up to whole cycles, never below one
   function automatic int unsigned min_cycles(input real ns);
      int unsigned n;
      n = int'($ceil(ns / CLK_PERIOD_NS - ROUND_SLACK));
      return (n < 1) ? 1 : n;
   endfunction

   // longest time, rounded down to whole cycles, never below one
   function automatic int unsigned max_cycles(input real ns);
      int unsigned n;
      n = int'($floor(ns / CLK_PERIOD_NS + ROUND_SLACK));
      return (n < 1) ? 1 : n;
   endfunction

   localparam int unsigned REL_SHORT_CYC  = min_cycles(REL_SHORT_MS * NS_PER_MS);
   localparam int unsigned REL_MID_CYC    = min_cycles(REL_MID_MS * NS_PER_MS);
   localparam int unsigned REL_LONG_CYC   = min_cycles(REL_LONG_MS * NS_PER_MS);
   localparam int unsigned FILT_CYC       = min_cycles(FILT_MIN_NS);
   localparam int unsigned ASSERT_MAX_CYC = max_cycles(ASSERT_MAX_US * NS_PER_US);
   localparam int unsigned SYNC_STAGES    = 2;

   ////////////////////////////////////////////////////////////////////////////
   // build options
   typedef enum {OUT_PUSH_LOW, OUT_PUSH_HIGH, OUT_OPEN_DRAIN} svrpg_out_mode_type;
   typedef enum {REL_SHORT, REL_MID, REL_LONG} svrpg_rel_sel_type;
   typedef enum {TRIP_L, TRIP_M, TRIP_T, TRIP_S, TRIP_R} svrpg_trip_type;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam int unsigned ADR_W   = 8;
   localparam int unsigned DAT_W   = 32;
   localparam int unsigned SEL_W   = DAT_W / 8;
   localparam logic [ADR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] REG_CONFIG = 8'h08;
   localparam logic [ADR_W-1:0] REG_COUNT  = 8'h0c;
   localparam logic [ADR_W-1:0] REG_CAUSE  = 8'h10;
   localparam logic [ADR_W-1:0] REG_EVENTS = 8'h14;

   // field positions
   localparam int unsigned CTRL_SOFT_BIT  = 0;
   localparam int unsigned ST_UV_BIT      = 0;
   localparam int unsigned ST_MAN_BIT     = 1;
   localparam int unsigned ST_SOFT_BIT    = 2;
   localparam int unsigned ST_COUNT_BIT   = 3;
   localparam int unsigned ST_ACTIVE_BIT  = 4;
   localparam int unsigned CFG_MODE_LSB   = 0;
   localparam int unsigned CFG_SEL_LSB    = 4;
   localparam int unsigned CFG_TRIP_LSB   = 8;
   localparam int unsigned CAUSE_W        = 3;
   localparam int unsigned EVENTS_W       = 16;

   // reset values
   localparam logic CTRL_SOFT_RESET = 1'h0;

endpackage

//--- svrpg_release_timer.sv
`timescale 1ns/1ps
module svrpg_release_timer #(
   parameter int unsigned TERM_CYC = svrpg_pkg::REL_LONG_CYC,
   parameter int unsigned CNT_W    = $clog2(TERM_CYC + 1)
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             hold,
   output logic                  expired,
   output logic [CNT_W-1:0]      count
);

   if (TERM_CYC < 1 || CNT_W < $clog2(TERM_CYC + 1)) begin : g_chk
      $error("release timer term or width out of range");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } svrpg_tmr_state_type;

   localparam svrpg_tmr_state_type RESET_STATE = '{cnt: '0};
   localparam logic [CNT_W-1:0]    TERM        = CNT_W'(TERM_CYC);

   svrpg_tmr_state_type q;
   svrpg_tmr_state_type d;

   always_comb begin
      d = q;
      if (hold) begin
         d.cnt = '0;
      end else if (q.cnt != TERM) begin
         d.cnt = q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign expired = (q.cnt == TERM);
   assign count   = q.cnt;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   a_clear_on_hold: assert property (hold |=> q.cnt == '0)
      else $error("timer not cleared by an active source");

   a_count_step: assert property (!hold && !expired |=> q.cnt == $past(q.cnt) + 1)
      else $error("timer did not advance while sources idle");

   a_term_stays: assert property (!hold && expired |=> expired)
      else $error("timer left its terminal count without a source");

endmodule

//--- svrpg_top.sv
// Overview of operation
// - output built push-low, push-high or open-drain
// - push-low: low while held, then high
// - push-high: high while held, then low
// - open-drain: pulls low, floats after delay
// - manual hold input active low, open means idle
// - manual hold input passes a noise filter
// - assert at power-up, undervoltage or manual hold
// - release delay option: 1.09, 17.5, 140 ms
// - undervoltage asserts output within 50 us
// - release only after full delay, not crossing
// - trip threshold is fixed build parameter
// - delay counts only when all three sources idle
// - any active source clears the delay counter
// - reject manual low pulses below 100 ns
`timescale 1ns/1ps
module svrpg_top #(
   parameter svrpg_pkg::svrpg_out_mode_type OUT_MODE  = svrpg_pkg::OUT_PUSH_LOW,
   parameter svrpg_pkg::svrpg_rel_sel_type  REL_SEL   = svrpg_pkg::REL_LONG,
   parameter svrpg_pkg::svrpg_trip_type     TRIP_CODE = svrpg_pkg::TRIP_L,
   parameter int unsigned REL_SHORT_CYC = svrpg_pkg::REL_SHORT_CYC,
   parameter int unsigned REL_MID_CYC   = svrpg_pkg::REL_MID_CYC,
   parameter int unsigned REL_LONG_CYC  = svrpg_pkg::REL_LONG_CYC,
   parameter int unsigned FILT_CYC      = svrpg_pkg::FILT_CYC
) (
   input  wire logic                          core_clk,
   input  wire logic                          reset_n,
   input  wire logic                          undervolt_in,
   input  wire logic                          manual_hold_n_in,
   output logic                               sys_rst_o,
   output logic                               sys_rst_oe,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [svrpg_pkg::ADR_W-1:0]   wb_adr_i,
   input  wire logic [svrpg_pkg::SEL_W-1:0]   wb_sel_i,
   input  wire logic [svrpg_pkg::DAT_W-1:0]   wb_dat_i,
   output logic [svrpg_pkg::DAT_W-1:0]        wb_dat_o,
   output logic                               wb_ack_o
);

   ////////////////////////////////////////////////////////////////////////////
   // build-time selection
   localparam int unsigned TERM_CYC =
      (REL_SEL == svrpg_pkg::REL_SHORT) ? REL_SHORT_CYC :
      (REL_SEL == svrpg_pkg::REL_MID)   ? REL_MID_CYC   : REL_LONG_CYC;
   localparam int unsigned CNT_W = $clog2(TERM_CYC + 1);
   localparam int unsigned DW    = svrpg_pkg::DAT_W;
   localparam int unsigned AW    = svrpg_pkg::ADR_W;
   localparam int unsigned CW    = svrpg_pkg::CAUSE_W;
   localparam int unsigned EW    = svrpg_pkg::EVENTS_W;
   localparam logic RST_PIN_O = (OUT_MODE == svrpg_pkg::OUT_PUSH_HIGH);

   if (REL_SHORT_CYC < 1 || REL_MID_CYC < 1 || REL_LONG_CYC < 1) begin : g_chk_rel
      $error("release delay counts must be at least one cycle");
   end
   if (CNT_W > DW) begin : g_chk_w
      $error("release counter wider than the data bus");
   end
   if (svrpg_pkg::SYNC_STAGES + 1 > svrpg_pkg::ASSERT_MAX_CYC) begin : g_chk_lat
      $error("undervoltage path slower than the assertion limit");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic          uv_meta;
      logic          uv_sync;
      logic          soft_hold;
      logic [CW-1:0] cause;
      logic [EW-1:0] events;
      logic          active;
      logic          pin_o;
      logic          pin_oe;
      logic          ack;
      logic [DW-1:0] dat;
   } svrpg_top_state_type;

   localparam svrpg_top_state_type RESET_STATE = '{
      uv_meta:   1'h1,
      uv_sync:   1'h1,
      soft_hold: svrpg_pkg::CTRL_SOFT_RESET,
      cause:     '0,
      events:    '0,
      active:    1'h1,
      pin_o:     RST_PIN_O,
      pin_oe:    1'h1,
      ack:       1'h0,
      dat:       '0};

   svrpg_top_state_type q;
   svrpg_top_state_type d;

   logic             man_req;
   logic             expired;
   logic [CNT_W-1:0] count;
   logic             hold_any;
   logic             bus_req;
   logic [CW-1:0]    cause_set;
   logic [CW-1:0]    cause_clr;
   logic [DW-1:0]    rdata;

   ////////////////////////////////////////////////////////////////////////////
   // sub-blocks
   svrpg_hold_filter #(
      .FILT_CYC (FILT_CYC)
   ) u_filter (
      .core_clk         (core_clk),
      .reset_n          (reset_n),
      .manual_hold_n_in (manual_hold_n_in),
      .hold_req         (man_req)
   );

   svrpg_release_timer #(
      .TERM_CYC (TERM_CYC),
      .CNT_W    (CNT_W)
   ) u_timer (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .hold     (hold_any),
      .expired  (expired),
      .count    (count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode helper
   function automatic logic reg_hit(input logic [AW-1:0] adr, input logic [AW-1:0] off);
      return adr[AW-1:2] == off[AW-1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // source combine and read mux
   always_comb begin
      hold_any  = q.uv_sync | man_req | q.soft_hold;
      bus_req   = wb_cyc_i & wb_stb_i & ~q.ack;
      cause_set = {q.soft_hold, man_req, q.uv_sync};
      cause_clr = '0;
      if (bus_req && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, svrpg_pkg::REG_CAUSE)) begin
         cause_clr = wb_dat_i[CW-1:0];
      end
      rdata = '0;
      if (reg_hit(wb_adr_i, svrpg_pkg::REG_CTRL)) begin
         rdata[svrpg_pkg::CTRL_SOFT_BIT] = q.soft_hold;
      end else if (reg_hit(wb_adr_i, svrpg_pkg::REG_STATUS)) begin
         rdata[svrpg_pkg::ST_UV_BIT]     = q.uv_sync;
         rdata[svrpg_pkg::ST_MAN_BIT]    = man_req;
         rdata[svrpg_pkg::ST_SOFT_BIT]   = q.soft_hold;
         rdata[svrpg_pkg::ST_COUNT_BIT]  = ~hold_any & ~expired;
         rdata[svrpg_pkg::ST_ACTIVE_BIT] = q.active;
      end else if (reg_hit(wb_adr_i, svrpg_pkg::REG_CONFIG)) begin
         rdata[svrpg_pkg::CFG_MODE_LSB +: 2] = 2'(OUT_MODE);
         rdata[svrpg_pkg::CFG_SEL_LSB +: 2]  = 2'(REL_SEL);
         rdata[svrpg_pkg::CFG_TRIP_LSB +: 3] = 3'(TRIP_CODE);
      end else if (reg_hit(wb_adr_i, svrpg_pkg::REG_COUNT)) begin
         rdata = DW'(count);
      end else if (reg_hit(wb_adr_i, svrpg_pkg::REG_CAUSE)) begin
         rdata[CW-1:0] = q.cause;
      end else if (reg_hit(wb_adr_i, svrpg_pkg::REG_EVENTS)) begin
         rdata[EW-1:0] = q.events;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      d.uv_meta = undervolt_in;
      d.uv_sync = q.uv_meta;
      d.active  = hold_any | ~expired;
      d.cause   = (q.cause & ~cause_clr) | cause_set;
      if (d.active && !q.active && q.events != '1) begin
         d.events = q.events + EW'(1);
      end
      case (OUT_MODE)
         svrpg_pkg::OUT_PUSH_LOW: begin
            d.pin_o  = ~d.active;
            d.pin_oe = 1'h1;
         end
         svrpg_pkg::OUT_PUSH_HIGH: begin
            d.pin_o  = d.active;
            d.pin_oe = 1'h1;
         end
         default: begin
            d.pin_o  = 1'h0;
            d.pin_oe = d.active;
         end
      endcase
      d.ack = bus_req;
      if (bus_req) begin
         d.dat = rdata;
         if (wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, svrpg_pkg::REG_CTRL)) begin
            d.soft_hold = wb_dat_i[svrpg_pkg::CTRL_SOFT_BIT];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   assign sys_rst_o  = q.pin_o;
   assign sys_rst_oe = q.pin_oe;
   assign wb_dat_o   = q.dat;
   assign wb_ack_o   = q.ack;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_sources_clear;
      hold_any ##1 !hold_any;
   endsequence

   sequence s_uv_steady;
      undervolt_in [*3];
   endsequence

   a_od_never_high: assert property (
         (OUT_MODE == svrpg_pkg::OUT_OPEN_DRAIN) |-> !sys_rst_o)
      else $error("open-drain output drove a high level");

   a_push_low_level: assert property (
         (OUT_MODE == svrpg_pkg::OUT_PUSH_LOW) && hold_any |=> sys_rst_oe && !sys_rst_o)
      else $error("active-low output not low while a source is active");

   a_push_high_level: assert property (
         (OUT_MODE == svrpg_pkg::OUT_PUSH_HIGH) && hold_any |=> sys_rst_oe && sys_rst_o)
      else $error("active-high output not high while a source is active");

   a_od_float_idle: assert property (
         (OUT_MODE == svrpg_pkg::OUT_OPEN_DRAIN) && !hold_any && expired |=> !sys_rst_oe)
      else $error("open-drain output still driving after the delay");

   a_hold_forces_active: assert property (hold_any |=> q.active)
      else $error("active source did not hold reset asserted");

   a_release_after_term: assert property (
         $fell(q.active) |-> $past(expired) && $past(!hold_any))
      else $error("reset released before the delay expired");

   a_uv_fast_assert: assert property (s_uv_steady |-> ##[0:1] q.active)
      else $error("undervoltage did not assert reset in time");

   a_no_release_at_clear: assert property (s_sources_clear |-> q.active ##1 q.active)
      else $error("reset released at the moment sources cleared");

   a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge held longer than one cycle");

   a_soft_write_lands: assert property (
         wb_ack_o && $past(wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, svrpg_pkg::REG_CTRL))
         |-> q.soft_hold == $past(wb_dat_i[svrpg_pkg::CTRL_SOFT_BIT]))
      else $error("control write did not update the software hold");

   a_cause_set_wins: assert property (q.uv_sync |=> q.cause[0])
      else $error("undervoltage cause bit lost");

endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   ////////////////////////////////////////////////////////////////////////////
   // bench signals
   logic        core_clk;
   logic        reset_n;
   logic        uv;
   logic        mh_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic        rst_o [3];
   logic        rst_oe [3];
   logic        ack [3];
   logic [31:0] rdat [3];
   logic        line [3];
   logic        in_rst [3];
   logic [31:0] rd_v [3];
   int          failures;
   int          n_tests;

   // rows: undervoltage, manual hold, cycles, expected held per instance
   localparam logic [12:0] ROWS [17] = '{
      {1'h0, 1'h1, 8'h3c, 3'h0}, {1'h1, 1'h1, 8'h04, 3'h7}, {1'h0, 1'h1, 8'h14, 3'h7},
      {1'h0, 1'h1, 8'h06, 3'h6}, {1'h0, 1'h1, 8'h0a, 3'h4}, {1'h0, 1'h1, 8'h0a, 3'h0},
      {1'h0, 1'h0, 8'h08, 3'h7}, {1'h0, 1'h1, 8'h14, 3'h7}, {1'h0, 1'h1, 8'h1e, 3'h0},
      {1'h0, 1'h0, 8'h01, 3'h0}, {1'h0, 1'h1, 8'h0a, 3'h0}, {1'h1, 1'h1, 8'h04, 3'h7},
      {1'h0, 1'h1, 8'h0f, 3'h7}, {1'h1, 1'h1, 8'h02, 3'h7}, {1'h0, 1'h1, 8'h12, 3'h7},
      {1'h0, 1'h1, 8'h0a, 3'h6}, {1'h0, 1'h1, 8'h1e, 3'h0}};

   ////////////////////////////////////////////////////////////////////////////
   // one instance per output build and delay option, with trip code T, S or R
   for (genvar m = 0; m < 3; m++) begin : g_dut
      svrpg_top #(
         .OUT_MODE      (svrpg_pkg::svrpg_out_mode_type'(m)),
         .REL_SEL       (svrpg_pkg::svrpg_rel_sel_type'(m)),
         .TRIP_CODE     (svrpg_pkg::svrpg_trip_type'(m + 2)),
         .REL_SHORT_CYC (20),
         .REL_MID_CYC   (30),
         .REL_LONG_CYC  (40)
      ) DUT (
         .core_clk         (core_clk),
         .reset_n          (reset_n),
         .undervolt_in     (uv),
         .manual_hold_n_in (mh_n),
         .sys_rst_o        (rst_o[m]),
         .sys_rst_oe       (rst_oe[m]),
         .wb_cyc_i         (cyc),
         .wb_stb_i         (stb),
         .wb_we_i          (we),
         .wb_adr_i         (adr),
         .wb_sel_i         (sel),
         .wb_dat_i         (wdat),
         .wb_dat_o         (rdat[m]),
         .wb_ack_o         (ack[m])
      );
      svrpg_mcu_model #(.OUT_MODE(svrpg_pkg::svrpg_out_mode_type'(m))) u_mcu (
         .pin_val  (rst_o[m]),
         .pin_en   (rst_oe[m]),
         .line     (line[m]),
         .in_reset (in_rst[m])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock, checks, bus
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // pin value and enable expected per build
   function automatic logic [1:0] pins(input int m, input logic act);
      case (m)
         0: return {~act, 1'b1};
         1: return {act, 1'b1};
         default: return {1'b0, act};
      endcase
   endfunction

   task automatic check_held(input logic [2:0] exp);
      for (int m = 0; m < 3; m++) begin
         check("held", {31'h0, in_rst[m]}, {31'h0, exp[m]});
         check("pins", {30'h0, rst_o[m], rst_oe[m]}, {30'h0, pins(m, exp[m])});
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack[0] !== 1'b1 && k < 20);
      check("ack", {31'h0, ack[0]}, 32'h1);
      for (int m = 0; m < 3; m++) rd_v[m] = rdat[m];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge core_clk);
      failures++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      failures = 0;
      n_tests  = 0;
      reset_n  = 1'b0;
      uv       = 1'b0;
      mh_n     = 1'b1;
      {cyc, stb, we} = 3'h0;
      adr  = 8'h00;
      sel  = 4'hf;
      wdat = 32'h0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (ROWS[i]) begin
         @(posedge core_clk);
         uv   <= ROWS[i][12];
         mh_n <= ROWS[i][11];
         repeat (ROWS[i][10:3]) @(posedge core_clk);
         @(negedge core_clk);
         check_held(ROWS[i][2:0]);
      end
      // build options readable, read-only
      wb(1'b1, svrpg_pkg::REG_CONFIG, 32'h0);
      wb(1'b0, svrpg_pkg::REG_CONFIG, 32'h0);
      for (int m = 0; m < 3; m++) begin
         check("config", rd_v[m], (m + 2) << 8 | m << 4 | m);
      end
      wb(1'b0, 8'h20, 32'h0);
      check("unmapped", rd_v[0], 32'h0);
      // software hold asserts the output
      wb(1'b1, svrpg_pkg::REG_CTRL, 32'h1);
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      check_held(3'h7);
      wb(1'b0, svrpg_pkg::REG_STATUS, 32'h0);
      for (int m = 0; m < 3; m++) check("status", rd_v[m], 32'h14);
      wb(1'b0, svrpg_pkg::REG_CAUSE, 32'h0);
      for (int m = 0; m < 3; m++) check("cause", rd_v[m], 32'h7);
      wb(1'b1, svrpg_pkg::REG_CAUSE, 32'h7);
      wb(1'b0, svrpg_pkg::REG_CAUSE, 32'h0);
      for (int m = 0; m < 3; m++) check("cause_clr", rd_v[m], 32'h4);
      wb(1'b1, svrpg_pkg::REG_CTRL, 32'h0);
      repeat (60) @(posedge core_clk);
      @(negedge core_clk);
      check_held(3'h0);
      wb(1'b0, svrpg_pkg::REG_COUNT, 32'h0);
      for (int m = 0; m < 3; m++) check("count", rd_v[m], 20 + 10 * m);
      // reset in mid-run, then power-up hold
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check_held(3'h7);
      @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (15) @(posedge core_clk);
      @(negedge core_clk);
      check_held(3'h7);
      repeat (60) @(posedge core_clk);
      @(negedge core_clk);
      check_held(3'h0);
      print_verdict();
   end
endmodule
